/* qpl_core.sv */
// Sampled position loop: host port, trajectory generator, summing junction, PID, outputs.
//
// Summary of operation
// - Every one of the four quadrature states is decoded, giving 4N counts per revolution with direction.
// - A 16-bit up-down counter stepped by the decoder holds the motion since the last sample.
// - With both channels and the index low together, the count is copied into the index latch.
// - A hardware sync pulse strobes the counter into the position latch at a fixed point each sample.
// - Just after the sync, the position latch is added into the 32-bit actual position.
// - Each sample the actual position is subtracted from the new desired position to form the filter error.
// - Each encoder state decode, index capture included, takes at least eight clocks.
// - Encoder inputs are synchronised to the clock, with no further noise filtering.
// - Each sample the trajectory generator computes a new desired position from host values.
// - Trajectory updates are taken during a move, but acceleration may not change then.
// - New filter coefficients may be loaded during motion and take effect when the host says.
// - Position, velocity and acceleration are 32-bit and the filter multiplies error by 16-bit gains.
// - The host port is an 8-bit two-way data bus plus six control lines with interrupt and reset.
// - The drive is a parallel word for a converter or a 7-bit pulse width with a sign output.
// - One sample lasts 2048 clock periods, the time unit of the loop.
`timescale 1ns/1ps
`default_nettype none
module qpl_core
   import qpl_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              quad_chan_a_i,
   input  wire logic              quad_chan_b_i,
   input  wire logic              quad_index_i,
   input  wire logic [7:0]        host_data_i,
   output logic      [7:0]        host_data_o,
   output logic                   host_data_oe_n_o,
   input  wire logic              host_cs_n_i,
   input  wire logic              host_rd_n_i,
   input  wire logic              host_wr_n_i,
   input  wire logic              host_ps_n_i,
   output logic                   host_irq_o,
   output logic      [DAC_W-1:0]  dac_word_o,
   output logic                   pwm_mag_o,
   output logic                   pwm_sign_o
);

   // Host pin synchronisers: {cs_n, ps_n, rd_n, wr_n}.
   logic [3:0]  hc_s1;
   logic [3:0]  hc_s2;
   logic [3:0]  hc_prev;
   logic [7:0]  hd_s1;
   logic [7:0]  hd_s2;
   logic        wr_done;
   logic        rd_done;
   logic        data_sel;

   // Sample timing.
   logic [10:0] smp_cnt;
   logic        sync_tick;

   // Decoder results.
   logic [CNT_W-1:0] pos_latch;
   logic [CNT_W-1:0] index_latch;
   logic             index_evt;

   // Host command state.
   logic [7:0]        cmd,      next_cmd;
   logic [31:0]       ld_shift, next_ld_shift;
   logic [1:0]        ld_cnt,   next_ld_cnt;
   logic [POS_W-1:0]  sh_acc,   next_sh_acc;
   logic [POS_W-1:0]  sh_vel,   next_sh_vel;
   logic [POS_W-1:0]  sh_pos,   next_sh_pos;
   logic [1:0]        sh_mode,  next_sh_mode;
   logic [COEF_W-1:0] sh_kp,    next_sh_kp;
   logic [COEF_W-1:0] sh_ki,    next_sh_ki;
   logic [COEF_W-1:0] sh_kd,    next_sh_kd;
   logic [COEF_W-1:0] kp,       next_kp;
   logic [COEF_W-1:0] ki,       next_ki;
   logic [COEF_W-1:0] kd,       next_kd;
   logic [31:0]       rbuf,     next_rbuf;
   logic              idx_flag, next_idx_flag;
   logic              start_p,  next_start_p;
   logic              stop_p,   next_stop_p;
   logic [7:0]        next_host_data;
   logic [31:0]       ld_word;

   // Loop state.
   qpl_loop_t                st,         next_st;
   logic [POS_W-1:0]         actual,     next_actual;
   logic [POS_W+FRAC_W-1:0]  des_pos,    next_des_pos;
   logic [POS_W+FRAC_W-1:0]  ramp_dist,  next_ramp_dist;
   logic [POS_W-1:0]         acc,        next_acc;
   logic [POS_W-1:0]         tgt_vel,    next_tgt_vel;
   logic [POS_W-1:0]         tgt_pos,    next_tgt_pos;
   logic [POS_W-1:0]         cur_vel,    next_cur_vel;
   logic [1:0]               mode,       next_mode;
   logic                     moving,     next_moving;
   logic                     decel,      next_decel;
   logic                     dir,        next_dir;
   logic signed [15:0]       err,        next_err;
   logic signed [15:0]       err_prev,   next_err_prev;
   logic signed [31:0]       integ,      next_integ;
   logic signed [11:0]       drive,      next_drive;
   logic [DAC_W-1:0]         next_dac;
   logic [PWM_W-1:0]         pwm_level,  next_pwm_level;
   logic                     next_pwm_sign;
   logic [PWM_W-1:0]         pwm_cnt;

   // Loop temporaries.
   logic [POS_W-1:0]         nv;
   logic [POS_W+FRAC_W-1:0]  step;
   logic [POS_W+FRAC_W-1:0]  tgt_fix;
   logic [POS_W+FRAC_W-1:0]  remain;
   logic signed [33:0]       err_full;
   logic signed [33:0]       u_sum;
   logic signed [11:0]       abs_drive;

   assign wr_done   = ~hc_prev[3] & ~hc_prev[0] & hc_s2[0];
   assign rd_done   = ~hc_prev[3] & ~hc_prev[1] & hc_s2[1];
   assign data_sel  = hc_prev[2];
   assign sync_tick = (smp_cnt == 11'h000);
   assign ld_word   = {ld_shift[23:0], hd_s2};

   qpl_decoder u_dec (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .quad_chan_a_i (quad_chan_a_i),
      .quad_chan_b_i (quad_chan_b_i),
      .quad_index_i  (quad_index_i),
      .sync_i        (sync_tick),
      .pos_latch_o   (pos_latch),
      .index_latch_o (index_latch),
      .index_evt_o   (index_evt)
   );

   // Host port: commands with select low, 4-byte big-endian data with it high.
   always_comb begin
      next_cmd      = cmd;
      next_ld_shift = ld_shift;
      next_ld_cnt   = ld_cnt;
      next_sh_acc   = sh_acc;
      next_sh_vel   = sh_vel;
      next_sh_pos   = sh_pos;
      next_sh_mode  = sh_mode;
      next_sh_kp    = sh_kp;
      next_sh_ki    = sh_ki;
      next_sh_kd    = sh_kd;
      next_kp       = kp;
      next_ki       = ki;
      next_kd       = kd;
      next_rbuf     = rbuf;
      next_idx_flag = idx_flag;
      next_start_p  = 1'b0;
      next_stop_p   = 1'b0;
      if (wr_done && !data_sel) begin
         next_cmd    = hd_s2;
         next_ld_cnt = 2'h0;
         case (hd_s2)
            CMD_MODE_POS: next_sh_mode = 2'h0;
            CMD_MODE_VF:  next_sh_mode = 2'h1;
            CMD_MODE_VR:  next_sh_mode = 2'h3;
            CMD_START:    next_start_p = 1'b1;
            CMD_STOP:     next_stop_p  = 1'b1;
            CMD_RD_POS:   next_rbuf    = actual;
            CMD_RD_INDEX: next_rbuf    = {16'h0000, index_latch};
            CMD_UPD_FILT: begin
               next_kp = sh_kp;
               next_ki = sh_ki;
               next_kd = sh_kd;
            end
            default: ;
         endcase
      end else if (wr_done) begin
         next_ld_shift = ld_word;
         next_ld_cnt   = ld_cnt + 2'h1;
         if (ld_cnt == 2'h3) begin
            case (cmd)
               CMD_SET_ACC: next_sh_acc = ld_word;
               CMD_SET_VEL: next_sh_vel = ld_word;
               CMD_SET_POS: next_sh_pos = ld_word;
               CMD_SET_KP:  next_sh_kp  = ld_word[15:0];
               CMD_SET_KI:  next_sh_ki  = ld_word[15:0];
               CMD_SET_KD:  next_sh_kd  = ld_word[15:0];
               default: ;
            endcase
         end
      end
      if (rd_done && data_sel) begin
         next_rbuf = {rbuf[23:0], 8'h00};
      end else if (rd_done) begin
         next_idx_flag = 1'b0;
      end
      // An index capture in the clearing cycle still raises the flag.
      if (index_evt) begin
         next_idx_flag = 1'b1;
      end
      next_host_data = 8'h00;
      if (data_sel) begin
         next_host_data = rbuf[31:24];
      end else begin
         next_host_data[ST_MOVING] = moving;
         next_host_data[ST_DECEL]  = decel;
         next_host_data[ST_INDEX]  = idx_flag;
         next_host_data[ST_VMODE]  = mode[0];
      end
   end

   // Sample sequence: accumulate, trajectory, junction, filter, drive.
   always_comb begin
      next_st        = st;
      next_actual    = actual;
      next_des_pos   = des_pos;
      next_ramp_dist = ramp_dist;
      next_acc       = acc;
      next_tgt_vel   = tgt_vel;
      next_tgt_pos   = tgt_pos;
      next_cur_vel   = cur_vel;
      next_mode      = mode;
      next_moving    = moving;
      next_decel     = decel;
      next_dir       = dir;
      next_err       = err;
      next_err_prev  = err_prev;
      next_integ     = integ;
      next_drive     = drive;
      nv             = cur_vel;
      step           = {{FRAC_W{1'b0}}, cur_vel};
      tgt_fix        = {tgt_pos, {FRAC_W{1'b0}}};
      remain         = dir ? des_pos - tgt_fix : tgt_fix - des_pos;
      err_full       = 34'(signed'(des_pos[47:16])) - 34'(signed'(actual));
      u_sum          = 34'($signed(kp) * err)
                     + 34'($signed(ki) * qpl_sat16(34'(integ)))
                     + 34'($signed(kd) * qpl_sat16(34'(err) - 34'(err_prev)));
      if (start_p) begin
         if (!moving) begin
            next_acc       = sh_acc;
            next_cur_vel   = 32'h0000_0000;
            next_ramp_dist = 48'h0;
         end
         next_tgt_vel = sh_vel;
         next_tgt_pos = sh_pos;
         next_mode    = sh_mode;
         next_moving  = 1'b1;
         next_decel   = 1'b0;
         next_dir     = sh_mode[0] ? sh_mode[1]
                                   : (signed'(sh_pos) < signed'(des_pos[47:16]));
      end
      if (stop_p) begin
         next_decel = 1'b1;
      end
      case (st)
         LS_IDLE: begin
            if (sync_tick) begin
               next_st = LS_ACCUM;
            end
         end
         LS_ACCUM: begin
            next_actual = actual + {{(POS_W-CNT_W){pos_latch[CNT_W-1]}}, pos_latch};
            if (moving) begin
               if (decel) begin
                  nv = (cur_vel > acc) ? cur_vel - acc : 32'h0000_0000;
               end else if (cur_vel + acc <= tgt_vel) begin
                  nv = cur_vel + acc;
               end else if (cur_vel > tgt_vel + acc) begin
                  nv = cur_vel - acc;
               end else begin
                  nv = tgt_vel;
               end
               step         = {{FRAC_W{1'b0}}, nv};
               next_cur_vel = nv;
               next_des_pos = dir ? des_pos - step : des_pos + step;
               if (!decel && nv > cur_vel) begin
                  next_ramp_dist = ramp_dist + step;
               end
               if (!mode[0]) begin
                  if (remain[47] || remain <= step) begin
                     next_des_pos = tgt_fix;
                     next_moving  = 1'b0;
                     next_cur_vel = 32'h0000_0000;
                  end else if (remain - step <= ramp_dist) begin
                     next_decel = 1'b1;
                  end
               end else if (decel && nv == 32'h0000_0000) begin
                  next_moving = 1'b0;
               end
            end
            next_st = LS_ERR;
         end
         LS_ERR: begin
            next_err = qpl_sat16(err_full);
            next_st  = LS_FILT;
         end
         LS_FILT: begin
            next_integ    = integ + 32'(err);
            next_err_prev = err;
            next_drive    = qpl_sat12(u_sum >>> OUT_SHIFT);
            next_st       = LS_OUT;
         end
         LS_OUT: begin
            next_st = LS_IDLE;
         end
         default: next_st = LS_IDLE;
      endcase
      abs_drive      = drive[11] ? -drive : drive;
      next_dac       = {~drive[11], drive[10:0]};
      next_pwm_level = abs_drive[10:4];
      next_pwm_sign  = drive[11];
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         hc_s1            <= 4'hF;
         hc_s2            <= 4'hF;
         hc_prev          <= 4'hF;
         hd_s1            <= 8'h00;
         hd_s2            <= 8'h00;
         smp_cnt          <= 11'h000;
         pwm_cnt          <= 7'h00;
         host_data_oe_n_o <= 1'b1;
      end else begin
         hc_s1            <= {host_cs_n_i, host_ps_n_i, host_rd_n_i, host_wr_n_i};
         hc_s2            <= hc_s1;
         hc_prev          <= hc_s2;
         hd_s1            <= host_data_i;
         hd_s2            <= hd_s1;
         smp_cnt          <= (smp_cnt == 11'(SAMPLE_CYCLES - 1)) ? 11'h000 : smp_cnt + 11'h001;
         pwm_cnt          <= pwm_cnt + 7'h01;
         host_data_oe_n_o <= hc_s2[3] | hc_s2[1];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmd         <= 8'h00;
         ld_shift    <= 32'h0000_0000;
         ld_cnt      <= 2'h0;
         sh_acc      <= 32'h0000_0000;
         sh_vel      <= 32'h0000_0000;
         sh_pos      <= 32'h0000_0000;
         sh_mode     <= 2'h0;
         sh_kp       <= 16'h0000;
         sh_ki       <= 16'h0000;
         sh_kd       <= 16'h0000;
         kp          <= 16'h0000;
         ki          <= 16'h0000;
         kd          <= 16'h0000;
         rbuf        <= 32'h0000_0000;
         idx_flag    <= 1'b0;
         start_p     <= 1'b0;
         stop_p      <= 1'b0;
         host_data_o <= 8'h00;
         host_irq_o  <= 1'b0;
      end else begin
         cmd         <= next_cmd;
         ld_shift    <= next_ld_shift;
         ld_cnt      <= next_ld_cnt;
         sh_acc      <= next_sh_acc;
         sh_vel      <= next_sh_vel;
         sh_pos      <= next_sh_pos;
         sh_mode     <= next_sh_mode;
         sh_kp       <= next_sh_kp;
         sh_ki       <= next_sh_ki;
         sh_kd       <= next_sh_kd;
         kp          <= next_kp;
         ki          <= next_ki;
         kd          <= next_kd;
         rbuf        <= next_rbuf;
         idx_flag    <= next_idx_flag;
         start_p     <= next_start_p;
         stop_p      <= next_stop_p;
         host_data_o <= next_host_data;
         host_irq_o  <= next_idx_flag;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st         <= LS_IDLE;
         actual     <= 32'h0000_0000;
         des_pos    <= 48'h0;
         ramp_dist  <= 48'h0;
         acc        <= 32'h0000_0000;
         tgt_vel    <= 32'h0000_0000;
         tgt_pos    <= 32'h0000_0000;
         cur_vel    <= 32'h0000_0000;
         mode       <= 2'h0;
         moving     <= 1'b0;
         decel      <= 1'b0;
         dir        <= 1'b0;
         err        <= 16'sh0000;
         err_prev   <= 16'sh0000;
         integ      <= 32'sh0000_0000;
         drive      <= 12'sh000;
         dac_word_o <= DAC_ZERO;
         pwm_level  <= 7'h00;
         pwm_sign_o <= 1'b0;
         pwm_mag_o  <= 1'b0;
      end else begin
         st         <= next_st;
         actual     <= next_actual;
         des_pos    <= next_des_pos;
         ramp_dist  <= next_ramp_dist;
         acc        <= next_acc;
         tgt_vel    <= next_tgt_vel;
         tgt_pos    <= next_tgt_pos;
         cur_vel    <= next_cur_vel;
         mode       <= next_mode;
         moving     <= next_moving;
         decel      <= next_decel;
         dir        <= next_dir;
         err        <= next_err;
         err_prev   <= next_err_prev;
         integ      <= next_integ;
         drive      <= next_drive;
         // Drive words change only in LS_OUT, a few clocks after the sync, so an unlatched DAC sees one value per sample.
         if (st == LS_OUT) begin
            dac_word_o <= next_dac;
            pwm_level  <= next_pwm_level;
            pwm_sign_o <= next_pwm_sign;
         end
         pwm_mag_o  <= (pwm_cnt < pwm_level);
      end
   end

endmodule
`default_nettype wire

/* qpl_pkg.sv */
// Shared constants, types and helpers for the quadrature position loop core.
package qpl_pkg;

   localparam int unsigned SAMPLE_CYCLES = 2048;
   localparam int unsigned DECODE_CYCLES = 8;
   localparam int unsigned CNT_W         = 16;
   localparam int unsigned POS_W         = 32;
   localparam int unsigned FRAC_W        = 16;
   localparam int unsigned COEF_W        = 16;
   localparam int unsigned DAC_W         = 12;
   localparam int unsigned PWM_W         = 7;
   localparam int unsigned OUT_SHIFT     = 8;

   localparam logic [11:0] DAC_ZERO = 12'h800;

   // Host command bytes, written with the port select line low.
   localparam logic [7:0] CMD_SET_ACC  = 8'h01;
   localparam logic [7:0] CMD_SET_VEL  = 8'h02;
   localparam logic [7:0] CMD_SET_POS  = 8'h03;
   localparam logic [7:0] CMD_SET_KP   = 8'h04;
   localparam logic [7:0] CMD_SET_KI   = 8'h05;
   localparam logic [7:0] CMD_SET_KD   = 8'h06;
   localparam logic [7:0] CMD_MODE_POS = 8'h07;
   localparam logic [7:0] CMD_MODE_VF  = 8'h08;
   localparam logic [7:0] CMD_MODE_VR  = 8'h09;
   localparam logic [7:0] CMD_START    = 8'h0A;
   localparam logic [7:0] CMD_UPD_FILT = 8'h0B;
   localparam logic [7:0] CMD_STOP     = 8'h0C;
   localparam logic [7:0] CMD_RD_POS   = 8'h0D;
   localparam logic [7:0] CMD_RD_INDEX = 8'h0E;

   // Status byte bit positions.
   localparam int unsigned ST_MOVING = 0;
   localparam int unsigned ST_DECEL  = 1;
   localparam int unsigned ST_INDEX  = 2;
   localparam int unsigned ST_VMODE  = 3;

   typedef enum logic [4:0] {
      LS_IDLE  = 5'h01,
      LS_ACCUM = 5'h02,
      LS_ERR   = 5'h04,
      LS_FILT  = 5'h08,
      LS_OUT   = 5'h10
   } qpl_loop_t;

   function automatic logic signed [15:0] qpl_sat16(input logic signed [33:0] v);
      if (v > 34'sd32767) begin
         return 16'sh7FFF;
      end else if (v < -34'sd32768) begin
         return 16'sh8000;
      end
      return v[15:0];
   endfunction

   // Symmetric clip keeps the magnitude of the most negative code in range.
   function automatic logic signed [11:0] qpl_sat12(input logic signed [33:0] v);
      if (v > 34'sd2047) begin
         return 12'sh7FF;
      end else if (v < -34'sd2047) begin
         return 12'sh801;
      end
      return v[11:0];
   endfunction

endpackage

/* qpl_decoder.sv */
// Quadrature decoder, sample-change counter, position latch and index latch.
`timescale 1ns/1ps
`default_nettype none
module qpl_decoder
   import qpl_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              quad_chan_a_i,
   input  wire logic              quad_chan_b_i,
   input  wire logic              quad_index_i,
   input  wire logic              sync_i,
   output logic      [CNT_W-1:0]  pos_latch_o,
   output logic      [CNT_W-1:0]  index_latch_o,
   output logic                   index_evt_o
);

   logic [2:0]       sync1;
   logic [2:0]       sync2;
   logic [2:0]       div;
   logic [2:0]       next_div;
   logic [1:0]       prev_ab;
   logic [1:0]       next_prev_ab;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [CNT_W-1:0] next_pos_latch;
   logic [CNT_W-1:0] next_index_latch;
   logic             next_index_evt;
   logic             tick;
   logic [1:0]       cur_ab;
   logic [CNT_W-1:0] step_cnt;

   assign tick   = (div == 3'(DECODE_CYCLES - 1));
   assign cur_ab = sync2[2:1];

   always_comb begin
      next_div         = tick ? 3'h0 : div + 3'h1;
      next_prev_ab     = prev_ab;
      next_index_latch = index_latch_o;
      next_index_evt   = 1'b0;
      step_cnt         = cnt;
      // One decode decision per eight clocks bounds the accepted state rate.
      if (tick) begin
         next_prev_ab = cur_ab;
         // A single-bit change is one quarter line; its sense gives direction.
         if (^(prev_ab ^ cur_ab)) begin
            step_cnt = (prev_ab[1] ^ cur_ab[0]) ? cnt + 16'h0001 : cnt - 16'h0001;
         end
         if (sync2 == 3'h0) begin
            next_index_latch = cnt;
            next_index_evt   = 1'b1;
         end
      end
      // The step seen at the sync edge opens the next period, so none is lost.
      next_pos_latch = pos_latch_o;
      next_cnt       = step_cnt;
      if (sync_i) begin
         next_pos_latch = cnt;
         next_cnt       = step_cnt - cnt;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync1         <= 3'h7;
         sync2         <= 3'h7;
         div           <= 3'h0;
         prev_ab       <= 2'h0;
         cnt           <= 16'h0000;
         pos_latch_o   <= 16'h0000;
         index_latch_o <= 16'h0000;
         index_evt_o   <= 1'b0;
      end else begin
         sync1         <= {quad_chan_a_i, quad_chan_b_i, quad_index_i};
         sync2         <= sync1;
         div           <= next_div;
         prev_ab       <= next_prev_ab;
         cnt           <= next_cnt;
         pos_latch_o   <= next_pos_latch;
         index_latch_o <= next_index_latch;
         index_evt_o   <= next_index_evt;
      end
   end

endmodule
`default_nettype wire

/* qpl_core_sva.sv */
// Port checker for the quadrature position loop core.
`timescale 1ns/1ps
`default_nettype none
module qpl_core_sva
   import qpl_pkg::*;
(
   input wire logic             clk_i,
   input wire logic             rst_i,
   input wire logic             quad_chan_a_i,
   input wire logic             quad_chan_b_i,
   input wire logic             quad_index_i,
   input wire logic             host_cs_n_i,
   input wire logic             host_rd_n_i,
   input wire logic             host_data_oe_n_o,
   input wire logic             host_irq_o,
   input wire logic [DAC_W-1:0] dac_word_o,
   input wire logic             pwm_sign_o
);
   int unsigned tk;
   int unsigned ig;
   // The gap saturates so a long quiet encoder cannot wrap back into range.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tk <= 0;
         ig <= 99;
      end else begin
         tk <= tk + 1;
         ig <= (!quad_chan_a_i && !quad_chan_b_i && !quad_index_i) ? 0 : (ig > 98 ? ig : ig + 1);
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence rd_sel; (!host_cs_n_i && !host_rd_n_i) [*4]; endsequence
   sequence no_sel; host_cs_n_i [*8]; endsequence
   oe_drive_a: assert property (rd_sel |-> !host_data_oe_n_o) else $error("bus idle on read");
   oe_float_a: assert property (no_sel |-> host_data_oe_n_o) else $error("bus driven unselected");
   oe_cause_a: assert property ($fell(host_data_oe_n_o) |-> $past(!host_cs_n_i && !host_rd_n_i, 2))
      else $error("bus driven without read");
   dac_hold_a: assert property ($changed(dac_word_o) |=> $stable(dac_word_o) [*8])
      else $error("drive word changed twice");
   dac_phase_a: assert property ($changed(dac_word_o) |-> (tk % SAMPLE_CYCLES) inside {[3:9]})
      else $error("drive word off sample phase");
   sign_match_a: assert property (pwm_sign_o == !dac_word_o[11]) else $error("sign mismatch");
   irq_cause_a: assert property ($rose(host_irq_o) |-> ig < 40)
      else $error("irq without index");
   irq_hold_a: assert property (no_sel ##0 host_irq_o |=> host_irq_o) else $error("irq lost");
endmodule
bind qpl_core qpl_core_sva chk_u (.*);
`default_nettype wire

/* qpl_enc_model.sv */
// Incremental encoder model: one state step every 16 clocks while running.
`timescale 1ns/1ps
`default_nettype none
module qpl_enc_model (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic run_i,
   input  wire logic fwd_i,
   input  wire logic idx_en_i,
   output logic      quad_chan_a_o,
   output logic      quad_chan_b_o,
   output logic      quad_index_o
);
   logic [1:0] ph;
   logic [3:0] dv;
   // Sixteen clocks a state keeps the rate inside what the decoder accepts.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ph <= 2'b00;
         dv <= 4'h0;
      end else begin
         dv <= run_i ? dv + 4'h1 : 4'h0;
         if (run_i && dv == 4'hF) ph <= fwd_i ? ph + 2'b01 : ph - 2'b01;
      end
   end
   assign quad_chan_a_o = ph[1];
   assign quad_chan_b_o = ph[1] ^ ph[0];
   assign quad_index_o  = !(idx_en_i && ph == 2'b00);
endmodule
`default_nettype wire

/* qpl_core_tb_top.sv */
// Self-checking testbench for the quadrature position loop core.
`timescale 1ns/1ps
`default_nettype none
module qpl_core_tb_top;
   import qpl_pkg::*;
   logic clk_i = 0, rst_i = 1, cs_n = 1, rd_n = 1, wr_n = 1, ps_n = 1;
   logic run = 0, fwd = 1, idx_en = 0;
   logic [7:0] hd = 8'h00, st;
   logic [31:0] w;
   wire logic qa, qb, qi, oe_n, irq, mag, sgn;
   wire logic [7:0] d_o, bus;
   wire logic [DAC_W-1:0] dac;
   int err_count = 0, compares = 0;
   assign bus = oe_n ? hd : d_o;
   qpl_enc_model enc_u (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .fwd_i(fwd), .idx_en_i(idx_en),
      .quad_chan_a_o(qa), .quad_chan_b_o(qb), .quad_index_o(qi));
   qpl_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .quad_chan_a_i(qa), .quad_chan_b_i(qb),
      .quad_index_i(qi), .host_data_i(bus), .host_data_o(d_o), .host_data_oe_n_o(oe_n),
      .host_cs_n_i(cs_n), .host_rd_n_i(rd_n), .host_wr_n_i(wr_n), .host_ps_n_i(ps_n),
      .host_irq_o(irq), .dac_word_o(dac), .pwm_mag_o(mag), .pwm_sign_o(sgn));
   initial forever #10 clk_i = !clk_i;
   task automatic cyc(input int n); repeat (n) @(posedge clk_i); endtask
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         $display("[FAIL] %0t exp %h got %h", $time, e, g);
         err_count++;
      end
   endtask
   task automatic hwr(input logic p, input logic [7:0] d);
      ps_n <= p; hd <= d; cs_n <= 0; wr_n <= 0; cyc(4);
      wr_n <= 1; cyc(4);
      cs_n <= 1; cyc(4);
   endtask
   // The host lets go of the bus on a read, so it shows the inverse of the last byte.
   task automatic hrd(input logic p, output logic [7:0] d);
      ps_n <= p; hd <= ~hd; cs_n <= 0; rd_n <= 0; cyc(6);
      d = d_o; rd_n <= 1; cyc(4);
      cs_n <= 1; cyc(4);
   endtask
   task automatic wcmd(input logic [7:0] c, input logic [31:0] v);
      hwr(0, c);
      for (int i = 3; i >= 0; i--) hwr(1, v[8*i+:8]);
   endtask
   task automatic rword(input logic [7:0] c);
      hwr(0, c);
      for (int i = 0; i < 4; i++) begin
         hrd(1, st);
         w = {w[23:0], st};
      end
   endtask
   task automatic steps(input logic f, input int k);
      fwd <= f; run <= 1; cyc(16 * k);
      run <= 0; cyc(2200);
   endtask
   task automatic t_reset;
      chk({20'h0, DAC_ZERO}, {20'h0, dac});
      chk(32'h0000_0008, {28'h0, oe_n, irq, mag, sgn});
      $display("t_reset done");
   endtask
   task automatic t_move;
      logic [31:0] n = 0;
      wcmd(CMD_SET_KP, 32'h0000_0800); hwr(0, CMD_UPD_FILT); hwr(0, CMD_MODE_POS);
      wcmd(CMD_SET_ACC, 32'h0001_0000); wcmd(CMD_SET_VEL, 32'h0004_0000);
      wcmd(CMD_SET_POS, 32'h0010_0000); hwr(0, CMD_START); cyc(12300);
      chk(1, dac > DAC_ZERO);
      // Count one full PWM period just after a drive update, so the level is steady.
      @(dac); cyc(1); repeat (128) begin @(posedge clk_i); n += mag; end
      chk((dac - DAC_ZERO) >> 4, n);
      hrd(0, st); chk(1, st[ST_MOVING]);
      wcmd(CMD_SET_KP, 32'h0000_0000); cyc(2100);
      chk(1, dac > DAC_ZERO);
      hwr(0, CMD_UPD_FILT); cyc(2100);
      chk({20'h0, DAC_ZERO}, {20'h0, dac});
      hwr(0, CMD_MODE_VF); hwr(0, CMD_START); hrd(0, st); chk(1, st[ST_VMODE]);
      hwr(0, CMD_STOP); hrd(0, st); chk(3, st[1:0]);
      cyc(10300); hrd(0, st); chk(0, st[ST_MOVING]);
      $display("t_move done");
   endtask
   task automatic t_count;
      steps(1, 40); rword(CMD_RD_POS); chk(32'h0000_0028, w);
      steps(0, 12); rword(CMD_RD_POS); chk(32'h0000_001C, w);
      $display("t_count done");
   endtask
   task automatic t_index;
      idx_en <= 1; cyc(40);
      idx_en <= 0; cyc(4);
      chk(1, irq);
      hrd(0, st); chk(1, st[ST_INDEX]); cyc(10);
      chk(0, irq);
      // No motion since the last sample, so the live count captured is zero.
      rword(CMD_RD_INDEX); chk(0, w);
      $display("t_index done");
   endtask
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      cyc(3);
      rst_i <= 0; cyc(2);
      t_reset; t_move; t_count; t_index;
      end_of_test;
   end
   initial begin
      cyc(60000);
      err_count++;
      end_of_test;
   end
endmodule
`default_nettype wire
